// ---- verilog/lpfm_pkg.sv ----
// Contract
// - Override bit 15: clock pin shows internal status
// - Override bit 14: second LED shows internal status
// - Override bit 13: first LED shows internal status
// - Bit 8 forces third LED to bit 7
// - Third LED exists only on clock pin
// - Bit 6 third LED polarity, resets high
// - Bit 5 forces second LED to bit 4
// - Bit 3 second LED polarity, inverse strap reset
// - Bit 2 forces first LED to bit 1
// - Bit 0 first LED polarity, inverse strap reset
// - Bits 10-8 select second LED pin function
// - Second LED function resets from receive-data-3 strap
// - Bits 14-12 select second LED clock source
// - Bit 15 halves second LED clock
// - Bit 11 inverts second LED clock
// - Bits 6-4 select first LED clock source
// - Bit 7 halves first LED clock
// - Bit 3 inverts first LED clock
// - Bits 2-0 select first LED pin function
// - Clock pin selector chooses its eight functions
package lpfm_pkg;

    // ****************************************************************
    // Register indices and byte addresses
    // ****************************************************************
    localparam logic [11:0] IDX_OVR = 12'h451;
    localparam logic [11:0] IDX_PFS = 12'h452;
    localparam logic [11:0] IDX_CKP = 12'h453;
    localparam logic [31:0] ADDR_OVR = {18'h00000, IDX_OVR, 2'h0};
    localparam logic [31:0] ADDR_PFS = {18'h00000, IDX_PFS, 2'h0};
    localparam logic [31:0] ADDR_CKP = {18'h00000, IDX_CKP, 2'h0};

    // ****************************************************************
    // Override register fields
    // ****************************************************************
    localparam int OVR_CKP_EXT = 15;
    localparam int OVR_L1_EXT  = 14;
    localparam int OVR_L0_EXT  = 13;
    localparam int OVR_L2_EN   = 8;
    localparam int OVR_L2_VAL  = 7;
    localparam int OVR_L2_POL  = 6;
    localparam int OVR_L1_EN   = 5;
    localparam int OVR_L1_VAL  = 4;
    localparam int OVR_L1_POL  = 3;
    localparam int OVR_L0_EN   = 2;
    localparam int OVR_L0_VAL  = 1;
    localparam int OVR_L0_POL  = 0;
    localparam logic [15:0] OVR_RESET = 16'h0049;
    localparam logic [15:0] OVR_MASK  = 16'hE1FF;

    // ****************************************************************
    // Pin function register fields
    // ****************************************************************
    localparam int PFS_L1_DIV = 15;
    localparam int PFS_L1_SRC = 12;
    localparam int PFS_L1_INV = 11;
    localparam int PFS_L1_FN  = 8;
    localparam int PFS_L0_DIV = 7;
    localparam int PFS_L0_SRC = 4;
    localparam int PFS_L0_INV = 3;
    localparam int PFS_L0_FN  = 0;
    localparam logic [15:0] PFS_RESET = 16'h0000;

    // ****************************************************************
    // Function codes and strap dependent reset values
    // ****************************************************************
    localparam logic [2:0] FN_LED   = 3'h0;
    localparam logic [2:0] FN_CLOCK = 3'h1;
    localparam logic [2:0] CKP_RESET_STRAP   = 3'h0;
    localparam logic [2:0] CKP_RESET_NOSTRAP = 3'h1;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

endpackage

// ---- verilog/lpfm_clk_path.sv ----
`timescale 1ns/1ns
module lpfm_clk_path #(
    parameter int NSRC = 8
) (
    // Clock and reset
    input  wire logic                    hclk,
    input  wire logic                    hresetn,
    // Sources and controls
    input  wire logic [NSRC-1:0]         src,
    input  wire logic [$clog2(NSRC)-1:0] sel,
    input  wire logic                    div_en,
    input  wire logic                    inv_en,
    // Result
    output logic                         clk_q
);

    logic cur;
    logic prev_q;
    logic half_q;
    logic shaped;

    // The sources are sampled level signals, so the halved copy toggles on each seen rise.
    assign cur    = src[sel];
    assign shaped = (div_en ? half_q : cur) ^ inv_en;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_q <= 1'b0;
            half_q <= 1'b0;
            clk_q  <= 1'b0;
        end else begin
            prev_q <= cur;
            if (cur && !prev_q) begin
                half_q <= ~half_q;
            end
            clk_q <= shaped;
        end
    end

endmodule

// ---- verilog/lpfm_top.sv ----
`timescale 1ns/1ns
module lpfm_top #(
    parameter int NSRC = 8
) (
    // AHB-Lite slave
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output logic                  hreadyout,
    output logic                  hresp,
    output logic [31:0]           hrdata,
    // Straps
    input  wire logic             rx_data3_bootstrap,
    input  wire logic             clock_pin_bootstrap,
    input  wire logic             led1_bootstrap,
    input  wire logic             led0_bootstrap,
    // Indicators and events
    input  wire logic [2:0]       led_ind,
    input  wire logic             wake_on_lan,
    input  wire logic             undervolt_evt,
    input  wire logic             ts_tx_evt,
    input  wire logic             ts_rx_evt,
    input  wire logic             esd_evt,
    input  wire logic             irq_evt,
    input  wire logic [7:0]       lp_status,
    // Clock sources
    input  wire logic [NSRC-1:0]  clk_src,
    input  wire logic             clock_mux_in,
    // Pins
    output logic                  led0_o,
    output logic                  led1_o,
    output logic                  clkpin_o
);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic led_drive(input logic en, input logic val,
                                       input logic ind, input logic pol);
        logic v;
        v = en ? val : ind;
        return pol ? v : ~v;
    endfunction

    function automatic logic pin_value(input logic ext, input logic [2:0] code,
                                       input logic led_v, input logic clk_v,
                                       input logic [7:0] ev, input logic [7:0] st);
        logic r;
        r = ev[code];
        if (ext) begin
            r = st[code];
        end else if (code == lpfm_pkg::FN_LED) begin
            r = led_v;
        end else if (code == lpfm_pkg::FN_CLOCK) begin
            r = clk_v;
        end
        return r;
    endfunction

    // ****************************************************************
    // Bus front end
    // ****************************************************************
    logic        wr_pend_q;
    logic [31:0] wr_addr_q;
    logic        strap_done_q;
    logic [15:0] ovr_q;
    logic [15:0] ovr_d;
    logic [15:0] pfs_q;
    logic [15:0] pfs_d;
    logic [2:0]  ckp_q;
    logic [2:0]  ckp_d;

    wire         take    = hsel && hready && htrans == lpfm_pkg::HTRANS_NONSEQ;
    wire         take_rd = take && !hwrite;
    wire         wr_ovr  = wr_pend_q && wr_addr_q == lpfm_pkg::ADDR_OVR;
    wire         wr_pfs  = wr_pend_q && wr_addr_q == lpfm_pkg::ADDR_PFS;
    wire         wr_ckp  = wr_pend_q && wr_addr_q == lpfm_pkg::ADDR_CKP;

    // Reads decode the next register values so a read right behind a write sees the new data.
    wire  [31:0] rd_mux  = (haddr == lpfm_pkg::ADDR_OVR) ? {16'h0000, ovr_d} :
                           (haddr == lpfm_pkg::ADDR_PFS) ? {16'h0000, pfs_d} :
                           (haddr == lpfm_pkg::ADDR_CKP) ? {29'h00000000, ckp_d} :
                           32'h00000000;

    // ****************************************************************
    // Register next values
    // ****************************************************************
    wire  [15:0] ovr_strap = {lpfm_pkg::OVR_RESET[15:4],
                              rx_data3_bootstrap ? ~clock_pin_bootstrap
                                                 : ~led1_bootstrap,
                              lpfm_pkg::OVR_RESET[2:1],
                              ~led0_bootstrap};
    wire  [15:0] pfs_strap = {lpfm_pkg::PFS_RESET[15:11],
                              rx_data3_bootstrap ? lpfm_pkg::FN_CLOCK
                                                 : lpfm_pkg::FN_LED,
                              lpfm_pkg::PFS_RESET[7:0]};
    wire  [2:0]  ckp_strap = rx_data3_bootstrap ? lpfm_pkg::CKP_RESET_STRAP
                                                : lpfm_pkg::CKP_RESET_NOSTRAP;

    assign ovr_d = !strap_done_q ? ovr_strap :
                   wr_ovr ? (hwdata[15:0] & lpfm_pkg::OVR_MASK) : ovr_q;
    assign pfs_d = !strap_done_q ? pfs_strap : wr_pfs ? hwdata[15:0] : pfs_q;
    assign ckp_d = !strap_done_q ? ckp_strap : wr_ckp ? hwdata[2:0] : ckp_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            strap_done_q <= 1'b0;
            ovr_q        <= lpfm_pkg::OVR_RESET;
            pfs_q        <= lpfm_pkg::PFS_RESET;
            ckp_q        <= lpfm_pkg::CKP_RESET_NOSTRAP;
        end else begin
            strap_done_q <= 1'b1;
            ovr_q        <= ovr_d;
            pfs_q        <= pfs_d;
            ckp_q        <= ckp_d;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 32'h00000000;
            hrdata    <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            wr_pend_q <= take && hwrite;
            wr_addr_q <= haddr;
            hrdata    <= take_rd ? rd_mux : 32'h00000000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // ****************************************************************
    // Clock paths
    // ****************************************************************
    logic clk0;
    logic clk1;

    lpfm_clk_path #(.NSRC(NSRC)) u_clk0 (
        .hclk    (hclk),
        .hresetn (hresetn),
        .src     (clk_src),
        .sel     (pfs_q[lpfm_pkg::PFS_L0_SRC +: 3]),
        .div_en  (pfs_q[lpfm_pkg::PFS_L0_DIV]),
        .inv_en  (pfs_q[lpfm_pkg::PFS_L0_INV]),
        .clk_q   (clk0)
    );

    lpfm_clk_path #(.NSRC(NSRC)) u_clk1 (
        .hclk    (hclk),
        .hresetn (hresetn),
        .src     (clk_src),
        .sel     (pfs_q[lpfm_pkg::PFS_L1_SRC +: 3]),
        .div_en  (pfs_q[lpfm_pkg::PFS_L1_DIV]),
        .inv_en  (pfs_q[lpfm_pkg::PFS_L1_INV]),
        .clk_q   (clk1)
    );

    // ****************************************************************
    // Pin selection
    // ****************************************************************
    wire  [7:0] ev_vec  = {irq_evt, esd_evt, ts_rx_evt, ts_tx_evt,
                           undervolt_evt, wake_on_lan, 2'b00};
    // The LED status list has no entry at code 110, which reads low.
    wire  [7:0] st_led  = {lp_status[7], 1'b0, lp_status[6], lp_status[4:0]};
    wire  [2:0] fn0     = pfs_q[lpfm_pkg::PFS_L0_FN +: 3];
    wire  [2:0] fn1     = pfs_q[lpfm_pkg::PFS_L1_FN +: 3];

    // Polarity acts on the indicator or its forced value only, never on a clock.
    wire        led0_v  = led_drive(ovr_q[lpfm_pkg::OVR_L0_EN], ovr_q[lpfm_pkg::OVR_L0_VAL],
                                    led_ind[0], ovr_q[lpfm_pkg::OVR_L0_POL]);
    wire        led1_v  = led_drive(ovr_q[lpfm_pkg::OVR_L1_EN], ovr_q[lpfm_pkg::OVR_L1_VAL],
                                    led_ind[1], ovr_q[lpfm_pkg::OVR_L1_POL]);
    wire        led2_v  = led_drive(ovr_q[lpfm_pkg::OVR_L2_EN], ovr_q[lpfm_pkg::OVR_L2_VAL],
                                    led_ind[2], ovr_q[lpfm_pkg::OVR_L2_POL]);

    wire        pin0_d  = pin_value(ovr_q[lpfm_pkg::OVR_L0_EXT], fn0, led0_v, clk0,
                                    ev_vec, st_led);
    wire        pin1_d  = pin_value(ovr_q[lpfm_pkg::OVR_L1_EXT], fn1, led1_v, clk1,
                                    ev_vec, st_led);
    // The third LED only reaches a pin through the clock pin's code 000.
    wire        pin2_d  = pin_value(ovr_q[lpfm_pkg::OVR_CKP_EXT], ckp_q, led2_v, clock_mux_in,
                                    ev_vec, lp_status);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            led0_o   <= 1'b0;
            led1_o   <= 1'b0;
            clkpin_o <= 1'b0;
        end else begin
            led0_o   <= pin0_d;
            led1_o   <= pin1_d;
            clkpin_o <= pin2_d;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    wire led0_led_mode = !ovr_q[lpfm_pkg::OVR_L0_EXT] && fn0 == lpfm_pkg::FN_LED;
    wire led1_led_mode = !ovr_q[lpfm_pkg::OVR_L1_EXT] && fn1 == lpfm_pkg::FN_LED;
    wire ckp_led_mode  = !ovr_q[lpfm_pkg::OVR_CKP_EXT] && ckp_q == lpfm_pkg::FN_LED;

    a_ckp_status: assert property (
        ovr_q[15] |=> clkpin_o == $past(lp_status[ckp_q]))
        else $error("clock pin does not show the chosen status");

    a_led1_status: assert property (
        (ovr_q[14] && fn1 == 3'h5) |=> led1_o == $past(lp_status[6]))
        else $error("second LED code 101 is not the receive state");

    a_led0_status: assert property (
        (ovr_q[13] && fn0 == 3'h7) |=> led0_o == $past(lp_status[7]))
        else $error("first LED code 111 is not the transmit enable");

    a_led2_force: assert property (
        (ckp_led_mode && ovr_q[8]) |=> clkpin_o == ($past(ovr_q[7]) ~^ $past(ovr_q[6])))
        else $error("third LED ignores its forced value");

    a_led1_force: assert property (
        (led1_led_mode && ovr_q[5]) |=> led1_o == ($past(ovr_q[4]) ~^ $past(ovr_q[3])))
        else $error("second LED ignores its forced value");

    a_led0_normal: assert property (
        (led0_led_mode && !ovr_q[2]) |=> led0_o == ($past(led_ind[0]) ~^ $past(ovr_q[0])))
        else $error("first LED does not follow its indicator");

    a_strap_load: assert property (
        $rose(strap_done_q) |-> pfs_q[10:8] == {2'b00, $past(rx_data3_bootstrap)}
                                && ovr_q[0] == !$past(led0_bootstrap))
        else $error("strap values not loaded after reset");

    a_led1_events: assert property (
        (!ovr_q[14] && fn1 == 3'h6) |=> led1_o == $past(esd_evt))
        else $error("second LED code 110 does not show the ESD event");

    a_ckp_clock: assert property (
        (!ovr_q[15] && ckp_q == 3'h1) |=> clkpin_o == $past(clock_mux_in))
        else $error("clock pin does not pass the clock mux");

    a_bus_write: assert property (
        (take && hwrite && haddr == lpfm_pkg::ADDR_OVR && strap_done_q)
            ##1 1'b1 |=> ovr_q == ($past(hwdata[15:0]) & lpfm_pkg::OVR_MASK))
        else $error("override register write lost");

    a_led0_force: assert property (
        (led0_led_mode && ovr_q[2]) |=> led0_o == ($past(ovr_q[1]) ~^ $past(ovr_q[0])))
        else $error("first LED ignores its forced value");

    a_led1_normal: assert property (
        (led1_led_mode && !ovr_q[5]) |=> led1_o == ($past(led_ind[1]) ~^ $past(ovr_q[3])))
        else $error("second LED does not follow its indicator");

    a_led2_normal: assert property (
        (ckp_led_mode && !ovr_q[8]) |=> clkpin_o == ($past(led_ind[2]) ~^ $past(ovr_q[6])))
        else $error("third LED does not follow its indicator");

    a_led2_hidden: assert property (
        (!ovr_q[15] && ckp_q == 3'h3) |=> clkpin_o == $past(undervolt_evt))
        else $error("clock pin code 011 does not show undervoltage");

    a_ckp_esd: assert property (
        (!ovr_q[15] && ckp_q == 3'h6) |=> clkpin_o == $past(esd_evt))
        else $error("clock pin code 110 does not show the ESD event");

    a_led0_wake: assert property (
        (!ovr_q[13] && fn0 == 3'h2) |=> led0_o == $past(wake_on_lan))
        else $error("first LED code 010 does not show wake on LAN");

    a_led0_stamp: assert property (
        (!ovr_q[13] && fn0 == 3'h5) |=> led0_o == $past(ts_rx_evt))
        else $error("first LED code 101 does not show the receive stamp");

    a_led1_irq: assert property (
        (!ovr_q[14] && fn1 == 3'h7) |=> led1_o == $past(irq_evt))
        else $error("second LED code 111 does not show the interrupt");

    a_led1_stamp: assert property (
        (!ovr_q[14] && fn1 == 3'h4) |=> led1_o == $past(ts_tx_evt))
        else $error("second LED code 100 does not show the transmit stamp");

    a_led0_dark: assert property (
        (ovr_q[13] && fn0 == 3'h6) |=> !led0_o)
        else $error("first LED status code 110 is not low");

    a_led1_power: assert property (
        (ovr_q[14] && fn1 == 3'h0) |=> led1_o == $past(lp_status[0]))
        else $error("second LED status code 000 is not power sequence done");

    a_led0_clock: assert property (
        (!ovr_q[13] && fn0 == lpfm_pkg::FN_CLOCK && !pfs_q[7] && $stable(pfs_q))
            |=> led0_o == $past(clk_src[pfs_q[6:4]] ^ pfs_q[3], 2))
        else $error("first LED does not show its chosen clock");

    a_led1_clock: assert property (
        (!ovr_q[14] && fn1 == lpfm_pkg::FN_CLOCK && !pfs_q[15] && $stable(pfs_q))
            |=> led1_o == $past(clk_src[pfs_q[14:12]] ^ pfs_q[11], 2))
        else $error("second LED does not show its chosen clock");

    a_led1_strap: assert property (
        $rose(strap_done_q) |-> ovr_q[3] == ($past(rx_data3_bootstrap)
                                             ? !$past(clock_pin_bootstrap)
                                             : !$past(led1_bootstrap)))
        else $error("second LED polarity strap not loaded");

    a_strap_others: assert property (
        $rose(strap_done_q) |-> ovr_q[6] && ckp_q == {2'b00, !$past(rx_data3_bootstrap)})
        else $error("third LED polarity or clock pin select wrong after reset");

    a_rd_unmapped: assert property (
        (take_rd && haddr != lpfm_pkg::ADDR_OVR && haddr != lpfm_pkg::ADDR_PFS
            && haddr != lpfm_pkg::ADDR_CKP) |=> hrdata == 32'h00000000)
        else $error("unmapped read does not return zero");

    a_rd_idle: assert property (
        !take_rd |=> hrdata == 32'h00000000)
        else $error("read data not zero outside a read data phase");

    a_rd_reserved: assert property (
        (take_rd && haddr == lpfm_pkg::ADDR_OVR) |=> hrdata[31:16] == 16'h0000
                                                     && hrdata[12:9] == 4'h0)
        else $error("override reserved bits do not read zero");

    c_led_force: cover property (led1_led_mode && ovr_q[5] ##1 ovr_q[5]);
    c_clock_out: cover property (fn0 == lpfm_pkg::FN_CLOCK && pfs_q[7] ##2 led0_o);
    c_ext_status: cover property (ovr_q[15] && ckp_q == 3'h6 ##1 clkpin_o);
    c_read_back: cover property (take_rd && haddr == lpfm_pkg::ADDR_PFS);

endmodule

// ---- dv/lpfm_led_load.sv ----
`timescale 1ns/1ns
// ****************************************************************
// Pin load model
// ****************************************************************
// The load counts level changes on each LED pin. It samples on the falling edge.
// A pin update at the rising edge is then never raced.
module lpfm_led_load (
    // Clock and control
    input  wire logic       hclk,
    input  wire logic       clr,
    // Pins
    input  wire logic       led0_o,
    input  wire logic       led1_o,
    // Counts
    output logic [7:0]      tog0,
    output logic [7:0]      tog1
);
    logic l0_q;
    logic l1_q;
    always @(negedge hclk) begin
        l0_q <= led0_o;
        l1_q <= led1_o;
        tog0 <= clr ? 8'h00 : tog0 + {7'h00, l0_q ^ led0_o};
        tog1 <= clr ? 8'h00 : tog1 + {7'h00, l1_q ^ led1_o};
    end
endmodule

// ---- dv/led_pin_function_mux_tb.sv ----
`timescale 1ns/1ns
module led_pin_function_mux_tb;
    // ****************************************************************
    // Stimulus and design
    // ****************************************************************
    logic        hclk    = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel    = 1'b0;
    logic [31:0] haddr   = 32'h0;
    logic [1:0]  htrans  = 2'h0;
    logic        hwrite  = 1'b0;
    logic [31:0] hwdata  = 32'h0;
    logic [3:0]  straps  = 4'h0;
    logic [17:0] stim    = 18'h0;
    logic [7:0]  clk_src = 8'h00;
    logic [7:0]  src_pat = 8'h00;
    logic [7:0]  run_mask = 8'h00;
    logic        clr     = 1'b1;
    int          tick    = 0;
    int          fails   = 0;
    int          checked = 0;
    wire logic        hready;
    wire logic        hreadyout;
    wire logic        hresp;
    wire logic [31:0] hrdata;
    wire logic        led0_o;
    wire logic        led1_o;
    wire logic        clkpin_o;
    wire logic        cmux;
    wire logic [2:0]  led_ind;
    wire logic [5:0]  evt;
    wire logic [7:0]  lp;
    wire logic [7:0]  tog0;
    wire logic [7:0]  tog1;
    assign hready = hreadyout;
    assign {cmux, led_ind, evt, lp} = stim;
    always #25 hclk = ~hclk;
    // The sources stay slower than half the bus clock so that the divider sees each edge.
    always @(posedge hclk) begin
        tick <= tick + 1;
        clk_src <= (run_mask == 8'h00) ? src_pat :
                   clk_src ^ (((tick % 3) == 0) ? run_mask : 8'h00);
    end
    lpfm_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .rx_data3_bootstrap(straps[3]), .clock_pin_bootstrap(straps[2]),
        .led1_bootstrap(straps[1]), .led0_bootstrap(straps[0]), .led_ind(led_ind),
        .wake_on_lan(evt[5]), .undervolt_evt(evt[4]), .ts_tx_evt(evt[3]),
        .ts_rx_evt(evt[2]), .esd_evt(evt[1]), .irq_evt(evt[0]), .lp_status(lp),
        .clk_src(clk_src), .clock_mux_in(cmux), .led0_o(led0_o), .led1_o(led1_o),
        .clkpin_o(clkpin_o));
    lpfm_led_load i_load (.hclk(hclk), .clr(clr), .led0_o(led0_o), .led1_o(led1_o),
        .tog0(tog0), .tog1(tog1));
    // ****************************************************************
    // Tasks
    // ****************************************************************
    task check(input logic [32:0] seen, input logic [32:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task print_verdict;
        $display("Comparisons %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task wait_rdy(output logic [32:0] got);
        logic rdy;
        do begin
            @(posedge hclk);
            rdy = hready;
            got = {hresp, hrdata};
        end while (rdy !== 1'b1);
    endtask
    task addr_ph(input logic [31:0] a, input logic w);
        logic [32:0] got;
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= lpfm_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        wait_rdy(got);
        htrans <= 2'h0;
        hsel <= 1'b0;
    endtask
    task bus_write(input logic [31:0] a, input logic [31:0] d);
        logic [32:0] got;
        addr_ph(a, 1'b1);
        hwdata <= d;
        wait_rdy(got);
    endtask
    task bus_read(input logic [31:0] a, input logic [31:0] exp);
        logic [32:0] got;
        addr_ph(a, 1'b0);
        wait_rdy(got);
        check(got, {1'b0, exp});
    endtask
    task do_reset(input logic [3:0] s);
        hresetn <= 1'b0;
        straps <= s;
        repeat (8) @(posedge hclk);
        check({30'h0, led0_o, led1_o, clkpin_o}, 33'h0);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
    endtask
    // ****************************************************************
    // Tests
    // ****************************************************************
    // Row: override, pin function, clock pin select, stimulus, {led0, led1, clock pin}.
    localparam logic [55:0] ROWS [20] = '{
        {16'h0049,16'h0000,3'h0,18'h14000,3'h5}, {16'h0000,16'h0000,3'h0,18'h14000,3'h2},
        {16'h01FE,16'h0000,3'h0,18'h00000,3'h3}, {16'h01C0,16'h0000,3'h1,18'h00000,3'h6},
        {16'h01C0,16'h0000,3'h1,18'h20000,3'h7}, {16'h0000,16'h0202,3'h2,18'h02000,3'h7},
        {16'h0000,16'h0303,3'h3,18'h01000,3'h7}, {16'h0000,16'h0404,3'h4,18'h00800,3'h7},
        {16'h0000,16'h0505,3'h5,18'h00400,3'h7}, {16'h0000,16'h0606,3'h6,18'h00200,3'h7},
        {16'h0000,16'h0707,3'h7,18'h00100,3'h7}, {16'hE000,16'h0000,3'h0,18'h00001,3'h7},
        {16'hE000,16'h0101,3'h1,18'h00002,3'h7}, {16'hE000,16'h0202,3'h2,18'h00004,3'h7},
        {16'hE000,16'h0303,3'h3,18'h00008,3'h7}, {16'hE000,16'h0404,3'h4,18'h00010,3'h7},
        {16'hE000,16'h0505,3'h5,18'h00040,3'h6}, {16'hE000,16'h0505,3'h5,18'h00020,3'h1},
        {16'hE000,16'h0606,3'h6,18'h00040,3'h1}, {16'hE000,16'h0707,3'h7,18'h00080,3'h7}};
    initial begin
        logic [55:0] row;
        logic [7:0]  v;
        logic [7:0]  cnt;
        do_reset(4'hD);
        bus_read(lpfm_pkg::ADDR_OVR, 32'h00000040);
        bus_read(lpfm_pkg::ADDR_PFS, 32'h00000100);
        bus_read(lpfm_pkg::ADDR_CKP, 32'h00000000);
        bus_write(lpfm_pkg::ADDR_OVR, 32'hFFFFFFFF);
        bus_read(lpfm_pkg::ADDR_OVR, 32'h0000E1FF);
        bus_write(lpfm_pkg::ADDR_PFS, 32'hFFFFFFFF);
        bus_read(lpfm_pkg::ADDR_PFS, 32'h0000FFFF);
        bus_write(lpfm_pkg::ADDR_CKP, 32'hFFFFFFFF);
        bus_read(lpfm_pkg::ADDR_CKP, 32'h00000007);
        bus_write(32'h00001150, 32'hFFFFFFFF);
        bus_read(32'h00001150, 32'h00000000);
        // A second reset in mid-run must pick up the new strap levels.
        do_reset(4'h4);
        bus_read(lpfm_pkg::ADDR_OVR, 32'h00000049);
        bus_read(lpfm_pkg::ADDR_PFS, 32'h00000000);
        bus_read(lpfm_pkg::ADDR_CKP, 32'h00000001);
        for (int r = 0; r < 20; r++) begin
            row = ROWS[r];
            bus_write(lpfm_pkg::ADDR_OVR, {16'h0000, row[55:40]});
            bus_write(lpfm_pkg::ADDR_PFS, {16'h0000, row[39:24]});
            bus_write(lpfm_pkg::ADDR_CKP, {29'h0, row[23:21]});
            stim <= row[20:3];
            repeat (4) @(posedge hclk);
            @(negedge hclk);
            check({30'h0, led0_o, led1_o, clkpin_o}, {30'h0, row[2:0]});
        end
        // Force bits set with active-low polarity must not touch clock outputs.
        bus_write(lpfm_pkg::ADDR_OVR, 32'h00000036);
        for (int p = 0; p < 2; p++) begin
            for (int s = 0; s < 8; s++) begin
                v = {1'b0, 3'(s), s[0], 3'h1};
                bus_write(lpfm_pkg::ADDR_PFS, (p != 0) ? {16'h0, v, 8'h00} : {24'h0, v});
                for (int k = 0; k < 2; k++) begin
                    src_pat <= (k != 0) ? ~(8'h01 << s) : (8'h01 << s);
                    repeat (5) @(posedge hclk);
                    @(negedge hclk);
                    check({32'h0, (p != 0) ? led1_o : led0_o}, {32'h0, s[0] ^ ~k[0]});
                end
            end
            for (int d = 0; d < 2; d++) begin
                v = {d[0], 3'h3, 1'b0, 3'h1};
                bus_write(lpfm_pkg::ADDR_PFS, (p != 0) ? {16'h0, v, 8'h00} : {24'h0, v});
                run_mask <= 8'h08;
                repeat (4) @(posedge hclk);
                clr <= 1'b1;
                @(posedge hclk);
                clr <= 1'b0;
                repeat (48) @(posedge hclk);
                cnt = (p != 0) ? tog1 : tog0;
                run_mask <= 8'h00;
                v = (d != 0) ? 8'h07 : 8'h0F;
                check({32'h0, cnt >= v && cnt <= v + 8'h02}, 33'h1);
            end
        end
        print_verdict;
    end
    initial begin
        #(50 * 20000);
        fails++;
        print_verdict;
    end
endmodule
